//--- design/trwg_noise_ring.sv
// One noise ring: a free-running inverter chain whose feedback is xored with bit 0 of a
// 16-bit LFSR. Assumes it is synthesised behaviourally; silicon substitutes an analog ring.
module trwg_noise_ring #(
  parameter logic [15:0] SEED_SALT = 16'h0001
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic noise_bit
);
  import trwg_pkg::*;

  typedef struct packed {
    logic [15:0] lfsr;
    logic [TRWG_RING_STAGES-1:0] chain;
  } trwg_ring_state_t;

  trwg_ring_state_t s_q;
  trwg_ring_state_t s_d;

  // ------------------------------------------------------------
  // Free-running ring model, stalled while the generator is off
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (run) begin
      s_d.lfsr = {s_q.lfsr[14:0], s_q.lfsr[15] ^ s_q.lfsr[13] ^ s_q.lfsr[12] ^ s_q.lfsr[10]};
      s_d.chain = {s_q.chain[TRWG_RING_STAGES-2:0], ~s_q.chain[TRWG_RING_STAGES-1] ^ s_q.lfsr[0]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q.lfsr <= SEED_SALT;
      s_q.chain <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign noise_bit = s_q.chain[TRWG_RING_STAGES-1];
endmodule

//--- design/trwg_pkg.sv
// Constants, register map and field layout of the random word generator.
// Assumes a single 50 MHz clock and an AXI4-Lite register bus.
//
// What this block does
// - Random words come from the internal noise source, with no seed register or seed input.
// - While enabled, new words are produced continuously and each completed one is stored.
// - Control bit 0 enables the generator; clearing it stops generation.
// - A simple scrambler breaks up long runs of equal bits before the word is stored.
// - Control bit 1 selects the raw ring output instead of the scrambled stream.
// - The value register holds the 32-bit word, is read-only and resets to zero.
// - Bit 3 of the flag register reports word done; all other bits are reserved.
// - Writing one to bit 3 of the clear register clears the done flag; zero does nothing.
// - Bit 3 of the mask register masks the done interrupt; the mask resets to 0x2.
package trwg_pkg;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [11:0] TRWG_ADDR_FLAGS = 12'h0444;
  localparam logic [11:0] TRWG_ADDR_CLEAR = 12'h0448;
  localparam logic [11:0] TRWG_ADDR_MASK = 12'h044c;
  localparam logic [11:0] TRWG_ADDR_CONTROL = 12'h049c;
  localparam logic [11:0] TRWG_ADDR_WORD = 12'h04a0;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int TRWG_BIT_DONE = 3;
  localparam int TRWG_BIT_ENABLE = 0;
  localparam int TRWG_BIT_RAW_SEL = 1;
  localparam logic [31:0] TRWG_MASK_RESET = 32'h0000_0002;
  localparam logic [31:0] TRWG_ZERO_RESET = 32'h0000_0000;
  localparam logic [1:0] TRWG_RESP_OKAY = 2'h0;
  localparam logic [1:0] TRWG_RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Noise source shape
  // ------------------------------------------------------------
  localparam int TRWG_RING_STAGES = 3;
  localparam int TRWG_RING_COUNT = 4;
  localparam logic [5:0] TRWG_WORD_BITS = 6'h20;
  localparam logic [5:0] TRWG_BITS_RESET = 6'h00;

endpackage

//--- design/trwg_top.sv
// Random word generator with AXI4-Lite register access and one level interrupt.
// Assumes a single clock aclk with synchronous active-low reset aresetn.
//
// Design decision made here: register access over AXI4-Lite.
module trwg_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  import trwg_pkg::*;

  typedef struct packed {
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic generator_enable;
    logic raw_output_select;
    logic word_ready_mask;
    logic word_ready_flag;
    logic [31:0] random_word;
    logic [31:0] shift_word;
    logic [5:0] bit_count;
    logic [6:0] scramble;
  } trwg_state_t;

  trwg_state_t s_q;
  trwg_state_t s_d;

  logic [TRWG_RING_COUNT-1:0] ring_bits;
  logic raw_bit;
  logic scr_bit;
  logic next_bit;
  logic do_write;
  logic clear_pulse;
  logic word_done;
  logic [31:0] mask_word;
  logic [31:0] flag_word;

  // ------------------------------------------------------------
  // Noise source: several rings folded by xor
  // ------------------------------------------------------------
  for (genvar i = 0; i < TRWG_RING_COUNT; i++) begin : g_ring
    trwg_noise_ring #(
      .SEED_SALT(16'(16'h1d35 * (i + 1)))
    ) u_ring (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(s_q.generator_enable),
      .noise_bit(ring_bits[i])
    );
  end

  assign raw_bit = ^ring_bits;
  // Multiplicative scrambler x^7 + x^6 + 1 stirs the stream against long runs
  assign scr_bit = raw_bit ^ s_q.scramble[6] ^ s_q.scramble[5];
  assign next_bit = s_q.raw_output_select ? raw_bit : scr_bit;
  assign word_done = s_q.generator_enable && (s_q.bit_count == TRWG_WORD_BITS - 6'h01);

  assign do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  assign clear_pulse = do_write && (s_q.aw_addr == TRWG_ADDR_CLEAR) && s_q.w_strb[0]
    && s_q.w_data[TRWG_BIT_DONE];

  always_comb begin
    mask_word = TRWG_ZERO_RESET;
    flag_word = TRWG_ZERO_RESET;
    // Mask reset value keeps bit 1 set; only bit 3 acts
    mask_word[TRWG_BIT_RAW_SEL] = 1'b1;
    mask_word[TRWG_BIT_DONE] = s_q.word_ready_mask;
    flag_word[TRWG_BIT_DONE] = s_q.word_ready_flag;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // Bus address and data channels, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end

    // Generator: one bit per cycle while enabled
    if (s_q.generator_enable) begin
      s_d.scramble = {s_q.scramble[5:0], scr_bit};
      s_d.shift_word = {s_q.shift_word[30:0], next_bit};
      s_d.bit_count = word_done ? TRWG_BITS_RESET : s_q.bit_count + 6'h01;
      if (word_done) begin
        s_d.random_word = {s_q.shift_word[30:0], next_bit};
      end
    end else begin
      s_d.bit_count = TRWG_BITS_RESET;
    end

    // Done flag: a set in the same cycle as a clear wins
    if (clear_pulse) begin
      s_d.word_ready_flag = 1'b0;
    end
    if (word_done) begin
      s_d.word_ready_flag = 1'b1;
    end

    // Write commit
    if (do_write) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = TRWG_RESP_OKAY;
      if (s_q.aw_addr == TRWG_ADDR_CONTROL) begin
        if (s_q.w_strb[0]) begin
          s_d.generator_enable = s_q.w_data[TRWG_BIT_ENABLE];
          s_d.raw_output_select = s_q.w_data[TRWG_BIT_RAW_SEL];
        end
      end else if (s_q.aw_addr == TRWG_ADDR_MASK) begin
        if (s_q.w_strb[0]) begin
          s_d.word_ready_mask = s_q.w_data[TRWG_BIT_DONE];
        end
      end else if (s_q.aw_addr == TRWG_ADDR_CLEAR || s_q.aw_addr == TRWG_ADDR_FLAGS
          || s_q.aw_addr == TRWG_ADDR_WORD) begin
        // Clear acts through clear_pulse; flags and value ignore writes
        s_d.bresp = TRWG_RESP_OKAY;
      end else begin
        s_d.bresp = TRWG_RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Read: answer one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = TRWG_RESP_OKAY;
      if (s_axi_araddr == TRWG_ADDR_FLAGS) begin
        s_d.rdata = flag_word;
      end else if (s_axi_araddr == TRWG_ADDR_CLEAR) begin
        s_d.rdata = TRWG_ZERO_RESET;
      end else if (s_axi_araddr == TRWG_ADDR_MASK) begin
        s_d.rdata = mask_word;
      end else if (s_axi_araddr == TRWG_ADDR_CONTROL) begin
        s_d.rdata = {30'h0000_0000, s_q.raw_output_select, s_q.generator_enable};
      end else if (s_axi_araddr == TRWG_ADDR_WORD) begin
        s_d.rdata = s_q.random_word;
      end else begin
        s_d.rdata = TRWG_ZERO_RESET;
        s_d.rresp = TRWG_RESP_SLVERR;
      end
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.word_ready_mask <= TRWG_MASK_RESET[TRWG_BIT_DONE];
      s_q.random_word <= TRWG_ZERO_RESET;
      s_q.scramble <= 7'h7f;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Address and data channels stay closed until the pending response is taken
  assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign irq = s_q.word_ready_flag && !s_q.word_ready_mask;
endmodule

//--- test/trwg_top_chk.sv
// Bus and interrupt checks for the random word generator.
// Bound to trwg_top; every port shares aclk.
module trwg_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import trwg_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence mask_set;
    wr_take ##0 s_axi_awaddr == TRWG_ADDR_MASK && s_axi_wdata[TRWG_BIT_DONE];
  endsequence
  b_lat_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("late bvalid");
  b_err_a: assert property (wr_take ##0 s_axi_awaddr < TRWG_ADDR_FLAGS |->
    ##[1:2] s_axi_bvalid && s_axi_bresp == TRWG_RESP_SLVERR) else $error("no write error");
  b_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready during bvalid");
  r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late rvalid");
  ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  bad_rd_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr < TRWG_ADDR_FLAGS |=>
    s_axi_rresp == TRWG_RESP_SLVERR && s_axi_rdata == TRWG_ZERO_RESET) else $error("bad read");
  flag_irq_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == TRWG_ADDR_FLAGS && irq |=>
    s_axi_rdata[TRWG_BIT_DONE]) else $error("irq without flag");
  mask_irq_a: assert property (mask_set |-> ##3 !irq [*2])
    else $error("masked irq high");
endmodule

bind trwg_top trwg_top_chk chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .irq);

//--- test/trwg_top_test.sv
// Self-checking bench for the random word generator over AXI4-Lite.
// Needs trwg_pkg and trwg_top; the checker binds itself.
module trwg_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import trwg_pkg::*;
  localparam logic [33:0] ALL = 34'h3_ffff_ffff;
  localparam logic [33:0] RSP = 34'h3_0000_0000;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, v1, v2;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_q[$], msk_q[$], me, mm;
  int fails = 0;
  int n_tests = 0;
  trwg_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    chk("bresp", {32'h0000_0000, s_axi_bresp}, {32'h0000_0000, r});
  endtask
  // Queues the expected answer; the monitor below compares it
  task automatic rd(input logic [11:0] a, input logic [33:0] e, input logic [33:0] m,
    output logic [31:0] d);
    exp_q.push_back(e);
    msk_q.push_back(m);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
  endtask
  task automatic wirq(input logic v);
    for (int i = 0; i < 100 && irq !== v; i++) @(posedge aclk);
    chk("irq", {33'h0, irq}, {33'h0, v});
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
      me = exp_q.pop_front();
      mm = msk_q.pop_front();
      chk("rdata", {s_axi_rresp, s_axi_rdata} & mm, me & mm);
    end
  end
  initial begin
    forever #10 aclk = ~aclk;
  end
  initial begin
    #100us;
    fails++;
    end_of_test();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(37));
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(TRWG_ADDR_FLAGS, 34'h0, ALL, v1);
    rd(TRWG_ADDR_CLEAR, 34'h0, ALL, v1);
    rd(TRWG_ADDR_MASK, {2'h0, TRWG_MASK_RESET}, ALL, v1);
    rd(TRWG_ADDR_CONTROL, 34'h0, ALL, v1);
    rd(TRWG_ADDR_WORD, 34'h0, ALL, v1);
    rd(12'h0400, 34'h2_0000_0000, ALL, v1);
    wr(TRWG_ADDR_WORD, $urandom(), TRWG_RESP_OKAY);
    wr(12'h0400, $urandom(), TRWG_RESP_SLVERR);
    rd(TRWG_ADDR_WORD, 34'h0, ALL, v1);
    $display("reset and map test done");
    wr(TRWG_ADDR_MASK, 32'h0000_0000, TRWG_RESP_OKAY);
    v1 = $urandom();
    wr(TRWG_ADDR_CONTROL, {v1[31:2], 2'h1}, TRWG_RESP_OKAY);
    rd(TRWG_ADDR_CONTROL, 34'h1, ALL, v1);
    wirq(1'h1);
    rd(TRWG_ADDR_FLAGS, 34'h8, ALL, v1);
    rd(TRWG_ADDR_WORD, 34'h0, RSP, v1);
    repeat (40) @(posedge aclk);
    rd(TRWG_ADDR_WORD, 34'h0, RSP, v2);
    chk("new word", {33'h0, v1 !== v2}, 34'h1);
    $display("scrambled run test done");
    wr(TRWG_ADDR_MASK, 32'h0000_0008, TRWG_RESP_OKAY);
    wirq(1'h0);
    rd(TRWG_ADDR_MASK, 34'ha, ALL, v1);
    wr(TRWG_ADDR_MASK, 32'h0000_0000, TRWG_RESP_OKAY);
    wirq(1'h1);
    $display("mask test done");
    wr(TRWG_ADDR_CONTROL, 32'h0000_0000, TRWG_RESP_OKAY);
    rd(TRWG_ADDR_WORD, 34'h0, RSP, v1);
    repeat (80) @(posedge aclk);
    rd(TRWG_ADDR_WORD, 34'h0, RSP, v2);
    chk("held word", {2'h0, v2}, {2'h0, v1});
    wr(TRWG_ADDR_CLEAR, 32'h0000_0000, TRWG_RESP_OKAY);
    rd(TRWG_ADDR_FLAGS, 34'h8, ALL, v1);
    wr(TRWG_ADDR_CLEAR, 32'h0000_0008, TRWG_RESP_OKAY);
    wirq(1'h0);
    rd(TRWG_ADDR_FLAGS, 34'h0, ALL, v1);
    rd(TRWG_ADDR_CLEAR, 34'h0, ALL, v1);
    $display("disable and clear test done");
    wr(TRWG_ADDR_CONTROL, 32'h0000_0003, TRWG_RESP_OKAY);
    rd(TRWG_ADDR_CONTROL, 34'h3, ALL, v1);
    wirq(1'h1);
    rd(TRWG_ADDR_WORD, 34'h0, RSP, v1);
    repeat (40) @(posedge aclk);
    rd(TRWG_ADDR_WORD, 34'h0, RSP, v2);
    chk("raw word", {33'h0, v1 !== v2}, 34'h1);
    $display("raw run test done");
    end_of_test();
  end
endmodule
